// [rtl/rtcai_pkg.sv]
package rtcai_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int SLOW_HZ       = 32_768;
  localparam int HALF_CYC      = CLK_HZ / (2 * SLOW_HZ);
  localparam int INC_DLY_US    = 92;
  localparam int INC_DLY_TICKS = INC_DLY_US * SLOW_HZ / 1_000_000;
  localparam int ADJ_MAX_US    = 3784;
  localparam int ADJ_MAX_TICKS = ADJ_MAX_US * SLOW_HZ / 1_000_000;
  localparam int ADJ_PERIOD_S  = 20;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_ALM_W = 4'h8;
  localparam logic [3:0] IDX_ALM_D = 4'hb;
  localparam logic [3:0] IDX_CTRL1 = 4'he;
  localparam logic [3:0] IDX_CTRL2 = 4'hf;

  localparam int C1_WEN   = 7;
  localparam int C1_DEN   = 6;
  localparam int C1_CKN_B = 4;
  localparam int C2_CKN_A = 3;
  localparam int C2_PFLAG = 2;
  localparam int C2_WFLAG = 1;
  localparam int C2_DFLAG = 0;

  localparam logic [2:0] SEL_OFF  = 3'h0;
  localparam logic [2:0] SEL_LOW  = 3'h1;
  localparam logic [2:0] SEL_2HZ  = 3'h2;
  localparam logic [2:0] SEL_1HZ  = 3'h3;
  localparam logic [2:0] SEL_SEC  = 3'h4;
  localparam logic [2:0] SEL_MIN  = 3'h5;
  localparam logic [2:0] SEL_HOUR = 3'h6;
  localparam logic [2:0] SEL_MON  = 3'h7;

  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] DAY_ONE  = 8'h01;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [2:0] wday;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtcai_time_t;

  typedef struct packed {
    logic [9:0]  div;
    logic        sq;
    logic [14:0] sub;
    logic [6:0]  hold;
    logic [4:0]  s20;
    logic        sec_inc;
  } rtcai_tb_t;

  typedef struct packed {
    logic        wen;
    logic        den;
    logic        ckn_a;
    logic        ckn_b;
    logic [2:0]  sel;
    logic        wflag;
    logic        dflag;
    logic        pflag;
    logic [7:0]  aw_min;
    logic [7:0]  aw_hour;
    logic [2:0]  aw_wday;
    logic [7:0]  ad_min;
    logic [7:0]  ad_hour;
    logic        wmatch_q;
    logic        dmatch_q;
    logic        inc_seen;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq_o;
    logic        irq_oe;
    logic        clk_out;
  } rtcai_state_t;

endpackage

// [rtl/rtcai_timebase.sv]
`timescale 1ns/10ps
module rtcai_timebase
  import rtcai_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              sec_write,
  input  wire logic              adj_en,
  input  wire logic signed [7:0] adj_ticks,
  output logic                   slow_sq,
  output logic [14:0]            sub,
  output logic                   sec_inc
);

  rtcai_tb_t  t;
  rtcai_tb_t  next_t;
  logic [7:0] mag;
  logic [6:0] lim;

  // ==========================================================================
  // Divider
  always_comb begin
    mag = adj_ticks[7] ? 8'(-adj_ticks) : 8'(adj_ticks);
    lim = (mag > 8'(ADJ_MAX_TICKS)) ? 7'(ADJ_MAX_TICKS) : mag[6:0];
    next_t = t;
    next_t.sec_inc = 1'b0;
    next_t.div = t.div + 10'h001;
    if (t.div == 10'(HALF_CYC - 1)) begin
      next_t.div = 10'h000;
      next_t.sq = ~t.sq;
      if (!t.sq) begin
        if (t.hold != 7'h00) begin
          next_t.hold = t.hold - 7'h01;
        end else if (t.sub == 15'h7fff) begin
          next_t.sub = 15'h0000;
          next_t.s20 = t.s20 + 5'h01;
          if (t.s20 == 5'(ADJ_PERIOD_S - 1)) begin
            next_t.s20 = 5'h00;
            // A shortened second skips its first ticks, so the increment
            // is issued at the wrap instead of after the usual delay.
            if (adj_en && adj_ticks[7] && lim != 7'h00) begin
              next_t.sub = 15'(lim);
              next_t.sec_inc = 1'b1;
            end else if (adj_en && !adj_ticks[7]) begin
              next_t.hold = lim;
            end
          end
        end else begin
          next_t.sub = t.sub + 15'h0001;
          next_t.sec_inc = (t.sub + 15'h0001 == 15'(INC_DLY_TICKS));
        end
      end
    end
    if (sec_write) begin
      next_t.div = 10'h000;
      next_t.sq = 1'b0;
      next_t.sub = 15'h0000;
      next_t.hold = 7'h00;
      next_t.sec_inc = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t <= '0;
    end else begin
      t <= next_t;
    end
  end

  assign slow_sq = t.sq;
  assign sub = t.sub;
  assign sec_inc = t.sec_inc;

endmodule

// [rtl/rtcai_core.sv]
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
module rtcai_core
  import rtcai_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire rtcai_time_t       now,
  input  wire logic              sec_write,
  input  wire logic              adj_en,
  input  wire logic signed [7:0] adj_ticks,
  input  wire logic              clkout_gate_pin,
  output logic                   sec_inc,
  output logic                   irq_n_out,
  output logic                   irq_n_oe,
  output logic                   slow_clock_out
);

  rtcai_state_t r;
  rtcai_state_t next_r;
  logic         slow_sq;
  logic [14:0]  sub;
  logic         setup;
  logic         acc;
  logic         wr_w;
  logic         wr_d;
  logic         wr_c1;
  logic         wr_c2;
  logic         mapped;
  logic         w_match;
  logic         d_match;
  logic         w_set;
  logic         d_set;
  logic         lvl_evt;
  logic         per_low;
  logic [31:0]  rdata;

  // ==========================================================================
  // Time base
  rtcai_timebase u_tb (
    .pclk      (pclk),
    .presetn   (presetn),
    .sec_write (sec_write),
    .adj_en    (adj_en),
    .adj_ticks (adj_ticks),
    .slow_sq   (slow_sq),
    .sub       (sub),
    .sec_inc   (sec_inc)
  );

  // ==========================================================================
  // Bus decode
  assign setup = psel && !penable;
  assign acc = psel && penable && r.pready && pwrite;
  assign mapped = (paddr[1:0] == 2'h0) &&
                  (paddr[5:2] == IDX_ALM_W || paddr[5:2] == IDX_ALM_D ||
                   paddr[5:2] == IDX_CTRL1 || paddr[5:2] == IDX_CTRL2) &&
                  (paddr[7:6] == 2'h0);
  assign wr_w = acc && mapped && paddr[5:2] == IDX_ALM_W;
  assign wr_d = acc && mapped && paddr[5:2] == IDX_ALM_D;
  assign wr_c1 = acc && mapped && paddr[5:2] == IDX_CTRL1;
  assign wr_c2 = acc && mapped && paddr[5:2] == IDX_CTRL2;

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr[5:2])
      IDX_ALM_W: rdata = {13'h0000, r.aw_wday, r.aw_hour, r.aw_min};
      IDX_ALM_D: rdata = {16'h0000, r.ad_hour, r.ad_min};
      IDX_CTRL1: begin
        rdata[C1_WEN] = r.wen;
        rdata[C1_DEN] = r.den;
        rdata[C1_CKN_B] = r.ckn_b;
        rdata[2:0] = r.sel;
      end
      IDX_CTRL2: begin
        rdata[C2_CKN_A] = r.ckn_a;
        rdata[C2_PFLAG] = r.pflag;
        rdata[C2_WFLAG] = r.wflag;
        rdata[C2_DFLAG] = r.dflag;
      end
      default: rdata = 32'h0000_0000;
    endcase
    if (!mapped) begin
      rdata = 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Alarm and periodic logic
  assign w_match = (now.wday == r.aw_wday) && (now.hour == r.aw_hour) &&
                   (now.min == r.aw_min);
  assign d_match = (now.hour == r.ad_hour) && (now.min == r.ad_min);
  // Only the first cycle of a match sets a flag, so an alarm re-enabled while
  // its time already matches waits for the next occurrence.
  assign w_set = w_match && !r.wmatch_q && r.wen;
  assign d_set = d_match && !r.dmatch_q && r.den;

  // The counters show the new time one cycle after the increment pulse.
  always_comb begin
    lvl_evt = 1'b0;
    if (r.inc_seen) begin
      case (r.sel)
        SEL_SEC:  lvl_evt = 1'b1;
        SEL_MIN:  lvl_evt = (now.sec == BCD_ZERO);
        SEL_HOUR: lvl_evt = (now.sec == BCD_ZERO) && (now.min == BCD_ZERO);
        SEL_MON:  lvl_evt = (now.sec == BCD_ZERO) && (now.min == BCD_ZERO) &&
                            (now.hour == BCD_ZERO) && (now.day == DAY_ONE);
        default:  lvl_evt = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (r.sel)
      SEL_OFF: per_low = 1'b0;
      SEL_LOW: per_low = 1'b1;
      SEL_2HZ: per_low = !sub[13];
      SEL_1HZ: per_low = !sub[14];
      default: per_low = r.pflag;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_r = r;
    next_r.pready = setup;
    next_r.pslverr = setup && !mapped;
    if (setup) begin
      next_r.prdata = rdata;
    end
    if (wr_w) begin
      next_r.aw_min = pwdata[7:0];
      next_r.aw_hour = pwdata[15:8];
      next_r.aw_wday = pwdata[18:16];
    end
    if (wr_d) begin
      next_r.ad_min = pwdata[7:0];
      next_r.ad_hour = pwdata[15:8];
    end
    if (wr_c1) begin
      next_r.wen = pwdata[C1_WEN];
      next_r.den = pwdata[C1_DEN];
      next_r.ckn_b = pwdata[C1_CKN_B];
      next_r.sel = pwdata[2:0];
    end
    if (wr_c2) begin
      next_r.ckn_a = pwdata[C2_CKN_A];
    end
    // Writing 1 leaves a flag alone; a set in the same cycle beats a clear.
    next_r.wflag = w_set || (r.wflag && !(wr_c2 && !pwdata[C2_WFLAG]));
    next_r.dflag = d_set || (r.dflag && !(wr_c2 && !pwdata[C2_DFLAG]));
    next_r.pflag = lvl_evt || (r.pflag && !(wr_c2 && !pwdata[C2_PFLAG]));
    next_r.wmatch_q = w_match;
    next_r.dmatch_q = d_match;
    next_r.inc_seen = sec_inc;
    next_r.irq_o = 1'b0;
    next_r.irq_oe = per_low || (r.wflag && r.wen) || (r.dflag && r.den);
    next_r.clk_out = slow_sq && clkout_gate_pin && !(r.ckn_a && r.ckn_b);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq_n_out = r.irq_o;
  assign irq_n_oe = r.irq_oe;
  assign slow_clock_out = r.clk_out;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A control write in the event cycle may change the mode, so it is excluded.
  sequence s_level_event;
    lvl_evt && !wr_c2 && !wr_c1;
  endsequence

  sequence s_flag_then_low;
    r.pflag ##1 r.irq_oe;
  endsequence

  AST_ALM_SET: assert property (w_set |=> r.wflag)
    else $error("weekday alarm match did not set its flag");

  AST_ALM_BLOCK: assert property ((r.sel == SEL_OFF) && !r.wen && !r.den && !wr_c1
                                  |=> ##1 !r.irq_oe)
    else $error("disabled alarms still pull the interrupt low");

  AST_FLAG_W1: assert property ((wr_c2 && pwdata[C2_WFLAG] && r.wflag) |=> r.wflag)
    else $error("writing one changed the weekday alarm flag");

  AST_FLAG_CLR: assert property ((wr_c2 && !pwdata[C2_DFLAG] && !d_set) |=> !r.dflag)
    else $error("writing zero did not clear the daily alarm flag");

  AST_EN_KEEP: assert property ((wr_c2 && !wr_c1) |=> $stable(r.wen) && $stable(r.den))
    else $error("clearing a flag changed an alarm enable");

  AST_NO_REFIRE: assert property ((r.wmatch_q && w_match && !r.wflag) |=> !r.wflag)
    else $error("alarm fired without a fresh match");

  AST_FIXED_LOW: assert property ((r.sel == SEL_LOW) && !wr_c1 |=> ##1 r.irq_oe)
    else $error("select 001 did not hold the interrupt low");

  AST_LEVEL: assert property ((s_level_event ##1 !wr_c1) |-> s_flag_then_low)
    else $error("level event did not set the flag and pull the output low");

  AST_SECWR: assert property ((sec_write && r.sel == SEL_1HZ && !wr_c1 ##1 !wr_c1)
                              |=> r.irq_oe)
    else $error("seconds write did not pull the pulse output low");

  AST_CLK_GATE: assert property ((!clkout_gate_pin || (r.ckn_a && r.ckn_b))
                                 |=> !slow_clock_out)
    else $error("clock output toggled while gated off");

endmodule

// [sim/rtcai_time_model.sv]
`timescale 1ns/10ps
module rtcai_time_model
  import rtcai_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ld,
  input  wire rtcai_time_t ld_time,
  input  wire logic        sec_inc,
  output rtcai_time_t      now,
  output logic             sec_write
);
  // ==========================================================================
  // Time counters
  // A load also reports a seconds write, so the divider restart is exercised.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      now       <= '0;
      sec_write <= 1'b0;
    end else begin
      sec_write <= ld;
      if (ld) begin
        now <= ld_time;
      end else if (sec_inc) begin
        // Only the seconds wrap; minute and hour stay as loaded.
        now.sec <= (now.sec == 8'h59) ? BCD_ZERO : now.sec + 8'h01;
      end
    end
  end
endmodule

// [sim/test_rtc_alarm_periodic_irq_clkout.sv]
`timescale 1ns/10ps
module test_rtc_alarm_periodic_irq_clkout
  import rtcai_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, ld, gate, err;
  logic        pready, pslverr, sec_inc, sec_write, irq_n_out, irq_n_oe, slow_clock_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  rtcai_time_t now, ld_time;
  int          miscompares, checked, cycles, tg;
  // The interrupt pin is open drain with a pull-up.
  wire         irq_n = irq_n_oe ? irq_n_out : 1'b1;

  rtcai_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .now(now), .sec_write(sec_write), .adj_en(1'b0),
    .adj_ticks(8'sh00), .clkout_gate_pin(gate), .sec_inc(sec_inc),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .slow_clock_out(slow_clock_out));
  rtcai_time_model partner (.pclk(pclk), .presetn(presetn), .ld(ld), .ld_time(ld_time),
    .sec_inc(sec_inc), .now(now), .sec_write(sec_write));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  // ==========================================================================
  // Checks and reporting
  task automatic finish_test();
    $display("counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // A register write reaches the pin one edge after the access completes.
  task automatic chk_irq(input logic exp, input string m);
    repeat (2) @(negedge pclk);
    chk_word({31'h0, irq_n}, {31'h0, exp}, m);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 50000) begin
      miscompares++;
      finish_test();
    end
  end

  // ==========================================================================
  // Bus and stimulus tasks
  // Pready is read at the rising edge, before that edge's updates land, so
  // read data are taken from the cycle in which they stand.
  task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk_word(32'h0, 32'h1, "no pready");
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp, input string m);
    apb(1'b0, idx, 32'h0);
    chk_word(rd, exp, m);
  endtask

  task automatic settime_s(input logic [2:0] w, input logic [7:0] h, input logic [7:0] m,
                           input logic [7:0] s);
    @(posedge pclk);
    ld      <= 1'b1;
    ld_time <= '{wday: w, day: DAY_ONE, hour: h, min: m, sec: s};
    @(posedge pclk);
    ld <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic settime(input logic [2:0] w, input logic [7:0] h, input logic [7:0] m);
    settime_s(w, h, m, BCD_ZERO);
  endtask

  // A load restarts the divider, so the next increment comes a few slow
  // ticks later instead of a full second.
  task automatic wait_tick();
    int n;
    n = 0;
    while (sec_inc !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) chk_word(32'h0, 32'h1, "no seconds tick");
    repeat (4) @(posedge pclk);
  endtask

  task automatic toggles(output int t);
    logic prev;
    t = 0;
    repeat (4) @(negedge pclk);
    prev = slow_clock_out;
    repeat (4 * HALF_CYC) begin
      @(negedge pclk);
      if (slow_clock_out !== prev) t++;
      prev = slow_clock_out;
    end
  endtask

  // ==========================================================================
  // Tests
  initial begin
    {presetn, psel, penable, pwrite, ld, gate, paddr, pwdata, ld_time} = '0;
    {miscompares, checked, cycles} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(IDX_CTRL1, 32'h0, "ctrl1 reset");
    rd_chk(IDX_CTRL2, 32'h0, "ctrl2 reset");
    chk_irq(1'b1, "irq idle");
    rd_chk(4'h1, 32'h0, "unmapped read");
    chk_word({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
    settime(3'h3, 8'h12, 8'h33);
    wr(IDX_CTRL1, 32'h0);
    wr(IDX_ALM_W, {13'h0, 3'h3, 8'h12, 8'h34});
    wr(IDX_CTRL1, 32'h80);
    settime(3'h4, 8'h12, 8'h34);
    rd_chk(IDX_CTRL2, 32'h0, "wrong weekday");
    settime(3'h3, 8'h12, 8'h34);
    rd_chk(IDX_CTRL2, 32'h2, "weekday match");
    chk_irq(1'b0, "weekday irq");
    wr(IDX_CTRL2, 32'h2);
    rd_chk(IDX_CTRL2, 32'h2, "write one kept");
    wr(IDX_CTRL2, 32'h0);
    rd_chk(IDX_CTRL2, 32'h0, "flag cleared");
    chk_irq(1'b1, "irq released");
    rd_chk(IDX_CTRL1, 32'h80, "enable kept");
    settime(3'h3, 8'h12, 8'h35);
    settime(3'h3, 8'h12, 8'h34);
    rd_chk(IDX_CTRL2, 32'h2, "rearmed");
    wr(IDX_CTRL2, 32'h0);
    $display("test weekday alarm done");
    wr(IDX_CTRL1, 32'h0);
    wr(IDX_ALM_D, {16'h0, 8'h12, 8'h34});
    wr(IDX_CTRL1, 32'h40);
    rd_chk(IDX_CTRL2, 32'h0, "no immediate");
    chk_irq(1'b1, "no immediate irq");
    settime(3'h4, 8'h12, 8'h35);
    settime(3'h6, 8'h12, 8'h34);
    rd_chk(IDX_CTRL2, 32'h1, "daily match");
    wr(IDX_CTRL1, 32'h41);
    wr(IDX_CTRL2, 32'h0);
    chk_irq(1'b0, "fixed low");
    rd_chk(IDX_CTRL2, 32'h0, "no flag fixed");
    wr(IDX_CTRL1, 32'h40);
    chk_irq(1'b1, "periodic off");
    $display("test daily alarm done");
    wr(IDX_CTRL1, 32'h2);
    settime(3'h6, 8'h12, 8'h34);
    chk_irq(1'b0, "pulse after seconds write");
    wr(IDX_CTRL1, 32'h0);
    chk_irq(1'b1, "pulse off");
    wr(IDX_CTRL1, 32'h3);
    settime(3'h6, 8'h12, 8'h34);
    chk_irq(1'b0, "1 Hz pulse after seconds write");
    wr(IDX_CTRL1, {29'h0, SEL_SEC});
    wait_tick();
    rd_chk(IDX_CTRL2, 32'h4, "second event flag");
    chk_irq(1'b0, "second event irq");
    wr(IDX_CTRL2, 32'h4);
    rd_chk(IDX_CTRL2, 32'h4, "periodic flag write one kept");
    wr(IDX_CTRL2, 32'h0);
    chk_irq(1'b1, "second event released");
    wr(IDX_CTRL1, {29'h0, SEL_MIN});
    settime_s(3'h6, 8'h12, 8'h34, 8'h59);
    wait_tick();
    rd_chk(IDX_CTRL2, 32'h4, "minute event flag");
    wr(IDX_CTRL2, 32'h0);
    wr(IDX_CTRL1, {29'h0, SEL_HOUR});
    settime_s(3'h6, 8'h12, 8'h00, 8'h59);
    wait_tick();
    rd_chk(IDX_CTRL2, 32'h4, "hour event flag");
    chk_irq(1'b0, "hour event irq");
    wr(IDX_CTRL2, 32'h0);
    wr(IDX_CTRL1, {29'h0, SEL_MON});
    settime_s(3'h6, 8'h00, 8'h00, 8'h59);
    wait_tick();
    rd_chk(IDX_CTRL2, 32'h4, "month event flag");
    wr(IDX_CTRL2, 32'h0);
    wr(IDX_CTRL1, {29'h0, SEL_HOUR});
    settime_s(3'h6, 8'h12, 8'h34, 8'h59);
    wait_tick();
    rd_chk(IDX_CTRL2, 32'h0, "no hour event off the hour");
    wr(IDX_CTRL1, 32'h0);
    $display("test pulse done");
    @(posedge pclk) gate <= 1'b1;
    toggles(tg);
    chk_word(tg, 32'h4, "clock runs");
    wr(IDX_CTRL1, 32'h10);
    toggles(tg);
    chk_word(tg, 32'h4, "one enable low");
    wr(IDX_CTRL2, 32'h08);
    toggles(tg);
    chk_word(tg, 32'h0, "both disabled");
    chk_word({31'h0, slow_clock_out}, 32'h0, "held low");
    wr(IDX_CTRL1, 32'h0);
    toggles(tg);
    chk_word(tg, 32'h4, "reenabled");
    @(posedge pclk) gate <= 1'b0;
    toggles(tg);
    chk_word(tg + slow_clock_out, 32'h0, "gate low");
    $display("test clock output done");
    finish_test();
  end
endmodule
